// ### logic/spdts_i2c_front.sv
`timescale 1ns/1ps
`include "spdts_cfg.svh"
// Notes on behaviour
// - Slave only; never drives the clock line
// - Type 1010 routes to memory array
// - Type 0110 routes to protect/page commands
// - Type 0011 routes to sensor registers
// - Memory and sensor sections act independently
// - Ninth bit is acknowledge; transmitter releases
// - Sensor: pointer then exactly two bytes
// - All bytes shift most significant bit first
// - Start is data fall with clock high
// - Stop is data rise with clock high
// - Stop after memory write starts write cycle
// - Nack then stop puts memory in standby
// - Nack writes to protected blocks, unchanged
// - Memory/sensor respond only on address match
// - Protect and page commands ignore address
// - Bit eight is direction; ack on match
// - No match: release bus, wait for start
// - Set/clear patterns need high-voltage first pin
// - Queries use same patterns, any pin level
// - Page select 110 lower, 111 upper
// - Page query acks page 0, nacks page 1
// - Four 128-byte blocks, persistent protection
// - Protect query acks unprotected, nacks protected
// - Page is 0 after every reset
module spdts_i2c_front #(
   parameter int LINE_W = `SPDTS_LINE_W
) (
   input wire logic clk,
   input wire logic nrst,
   input wire logic scl_in,
   input wire logic sda_in,
   output logic sda_out,
   output logic sda_oe_n,
   input wire logic first_address_pin,
   input wire logic second_address_pin,
   input wire logic third_address_pin,
   input wire logic high_voltage_level,
   input wire logic mem_write_busy,
   input wire logic [7:0] mem_rd_data,
   input wire logic [3:0] prot_state,
   input wire logic [15:0] ts_rd_data,
   output logic page_select,
   output logic [7:0] mem_addr,
   output logic [7:0] mem_wr_data,
   output logic mem_wr_stb,
   output logic mem_rd_stb,
   output logic mem_nv_write_start,
   output logic mem_standby,
   output logic block_protect_set,
   output logic [3:0] block_protect_mask,
   output logic protect_clear_all,
   output logic [7:0] ts_pointer,
   output logic [15:0] ts_wr_data,
   output logic ts_wr_stb
);

   spdts_pkg::spdts_state_e state_r;
   spdts_pkg::spdts_tgt_e tgt_r;
   spdts_pkg::spdts_tgt_e tgt_nxt;
   spdts_pkg::spdts_pcmd_e pcmd_nxt;
   logic scl_q_r;
   logic sda_q_r;
   logic [3:0] bit_cnt_r;
   logic [7:0] shift_r;
   logic [1:0] idx_r;
   logic rnw_r;
   logic last_ack_r;
   logic mst_ack_r;
   logic wr_pend_r;
   logic prot_pend_r;
   logic prot_clr_pend_r;
   logic [1:0] prot_blk_r;
   logic [7:0] ts_hi_r;
   logic [1:0] blk_nxt;
   logic [2:0] logical_select_address;
   logic ack_nxt;
   logic scl_rise;
   logic scl_fall;
   logic start_det;
   logic stop_det;
   logic rx_phase;
   logic byte_in;
   logic next_fall;
   logic tx_load;
   logic [1:0] tx_cnt;
   logic [7:0] tx_byte;
   logic blk_locked;
   logic stop_after_ack;

   assign logical_select_address = {third_address_pin, second_address_pin, first_address_pin};
   assign scl_rise = scl_in && !scl_q_r;
   assign scl_fall = !scl_in && scl_q_r;
   assign start_det = scl_in && scl_q_r && sda_q_r && !sda_in;
   assign stop_det = scl_in && scl_q_r && !sda_q_r && sda_in;
   assign rx_phase = (state_r == spdts_pkg::ST_SEL) || (state_r == spdts_pkg::ST_RX);
   assign byte_in = rx_phase && scl_fall && (bit_cnt_r == `SPDTS_ACK_SLOT);
   assign next_fall = scl_fall && (bit_cnt_r == `SPDTS_NEXT_SLOT);
   // Block index is {page, address bit 7}
   assign blk_locked = prot_state[{page_select, mem_addr[7]}];
   assign tx_cnt = (state_r == spdts_pkg::ST_SEL) ? 2'h0 : idx_r;
   assign tx_load = next_fall && (((state_r == spdts_pkg::ST_SEL) && last_ack_r && rnw_r
                    && (tgt_r == spdts_pkg::TGT_MEM || tgt_r == spdts_pkg::TGT_TS))
                    || ((state_r == spdts_pkg::ST_TX) && mst_ack_r));
   // Stop inside the tenth bit slot, right after an acked byte
   assign stop_after_ack = stop_det && (state_r == spdts_pkg::ST_RX)
                           && (bit_cnt_r == `SPDTS_STOP_SLOT) && last_ack_r;

   always_comb begin
      if (tgt_r == spdts_pkg::TGT_TS) begin
         if (tx_cnt == 2'h0) begin
            tx_byte = ts_rd_data[15:8];
         end else if (tx_cnt == 2'h1) begin
            tx_byte = ts_rd_data[7:0];
         end else begin
            tx_byte = `SPDTS_IDLE_BYTE;
         end
      end else begin
         tx_byte = mem_rd_data;
      end
   end

   // Protection-type decode of {b3,b2,b1,direction}
   always_comb begin
      pcmd_nxt = spdts_pkg::PC_NONE;
      blk_nxt = 2'h0;
      case (shift_r[3:0])
         `SPDTS_PC_SET0: begin
            pcmd_nxt = spdts_pkg::PC_SET;
            blk_nxt = 2'h0;
         end
         `SPDTS_PC_SET1: begin
            pcmd_nxt = spdts_pkg::PC_SET;
            blk_nxt = 2'h1;
         end
         `SPDTS_PC_SET2: begin
            pcmd_nxt = spdts_pkg::PC_SET;
            blk_nxt = 2'h2;
         end
         `SPDTS_PC_SET3: begin
            pcmd_nxt = spdts_pkg::PC_SET;
            blk_nxt = 2'h3;
         end
         `SPDTS_PC_CLEAR: pcmd_nxt = spdts_pkg::PC_CLEAR;
         `SPDTS_PC_QRY0: begin
            pcmd_nxt = spdts_pkg::PC_QUERY;
            blk_nxt = 2'h0;
         end
         `SPDTS_PC_QRY1: begin
            pcmd_nxt = spdts_pkg::PC_QUERY;
            blk_nxt = 2'h1;
         end
         `SPDTS_PC_QRY2: begin
            pcmd_nxt = spdts_pkg::PC_QUERY;
            blk_nxt = 2'h2;
         end
         `SPDTS_PC_QRY3: begin
            pcmd_nxt = spdts_pkg::PC_QUERY;
            blk_nxt = 2'h3;
         end
         `SPDTS_PC_PAGE0: pcmd_nxt = spdts_pkg::PC_PAGE0;
         `SPDTS_PC_PAGE1: pcmd_nxt = spdts_pkg::PC_PAGE1;
         `SPDTS_PC_PQRY: pcmd_nxt = spdts_pkg::PC_PQUERY;
         default: pcmd_nxt = spdts_pkg::PC_NONE;
      endcase
   end

   // Acknowledge decision for the byte just received
   always_comb begin
      ack_nxt = 1'b0;
      tgt_nxt = tgt_r;
      if (state_r == spdts_pkg::ST_SEL) begin
         tgt_nxt = spdts_pkg::TGT_NONE;
         case (shift_r[7:4])
            `SPDTS_TYPE_MEM: begin
               // Memory stays deaf while its write cycle runs; sensor does not
               tgt_nxt = spdts_pkg::TGT_MEM;
               ack_nxt = (shift_r[3:1] == logical_select_address) && !mem_write_busy;
            end
            `SPDTS_TYPE_TS: begin
               tgt_nxt = spdts_pkg::TGT_TS;
               ack_nxt = (shift_r[3:1] == logical_select_address);
            end
            `SPDTS_TYPE_PROT: begin
               tgt_nxt = spdts_pkg::TGT_PROT;
               case (pcmd_nxt)
                  spdts_pkg::PC_SET: ack_nxt = high_voltage_level;
                  spdts_pkg::PC_CLEAR: ack_nxt = high_voltage_level;
                  spdts_pkg::PC_PAGE0: ack_nxt = 1'b1;
                  spdts_pkg::PC_PAGE1: ack_nxt = 1'b1;
                  spdts_pkg::PC_QUERY: ack_nxt = !prot_state[blk_nxt];
                  spdts_pkg::PC_PQUERY: ack_nxt = !page_select;
                  default: ack_nxt = 1'b0;
               endcase
            end
            default: ack_nxt = 1'b0;
         endcase
      end else begin
         case (tgt_r)
            spdts_pkg::TGT_MEM: ack_nxt = (idx_r == 2'h0) || !blk_locked;
            spdts_pkg::TGT_TS: ack_nxt = (idx_r <= `SPDTS_TS_BYTES);
            spdts_pkg::TGT_PROT: ack_nxt = 1'b1;
            default: ack_nxt = 1'b0;
         endcase
      end
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         scl_q_r <= 1'b1;
         sda_q_r <= 1'b1;
      end else begin
         scl_q_r <= scl_in;
         sda_q_r <= sda_in;
      end
   end

   // Byte engine; no clock output exists, so no stretching is possible
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         state_r <= spdts_pkg::ST_IDLE;
         tgt_r <= spdts_pkg::TGT_NONE;
         bit_cnt_r <= 4'h0;
         shift_r <= 8'h00;
         idx_r <= 2'h0;
         rnw_r <= 1'b0;
         last_ack_r <= 1'b0;
         mst_ack_r <= 1'b0;
         sda_oe_n <= 1'b1;
         sda_out <= 1'b0;
      end else if (start_det) begin
         state_r <= spdts_pkg::ST_SEL;
         bit_cnt_r <= 4'h0;
         idx_r <= 2'h0;
         sda_oe_n <= 1'b1;
      end else if (stop_det) begin
         state_r <= spdts_pkg::ST_IDLE;
         tgt_r <= spdts_pkg::TGT_NONE;
         sda_oe_n <= 1'b1;
      end else if (state_r == spdts_pkg::ST_IDLE || state_r == spdts_pkg::ST_WAIT) begin
         sda_oe_n <= 1'b1;
      end else if (scl_rise && bit_cnt_r != `SPDTS_NEXT_SLOT) begin
         bit_cnt_r <= bit_cnt_r + 4'h1;
         if (rx_phase && bit_cnt_r < `SPDTS_ACK_SLOT) begin
            shift_r <= {shift_r[6:0], sda_in};
         end
         if (state_r == spdts_pkg::ST_TX && bit_cnt_r == `SPDTS_ACK_SLOT) begin
            mst_ack_r <= !sda_in;
         end
      end else if (scl_fall) begin
         if (byte_in) begin
            sda_oe_n <= !ack_nxt;
            last_ack_r <= ack_nxt;
            if (state_r == spdts_pkg::ST_SEL) begin
               tgt_r <= tgt_nxt;
               rnw_r <= shift_r[0];
            end
         end else if (bit_cnt_r == `SPDTS_ACK_SLOT) begin
            sda_oe_n <= 1'b1;
         end else if (bit_cnt_r == `SPDTS_NEXT_SLOT) begin
            bit_cnt_r <= 4'h0;
            sda_oe_n <= 1'b1;
            if (tx_load) begin
               state_r <= spdts_pkg::ST_TX;
               shift_r <= tx_byte;
               sda_oe_n <= tx_byte[7];
               idx_r <= (tx_cnt == `SPDTS_IDX_MAX) ? tx_cnt : tx_cnt + 2'h1;
            end else if (state_r == spdts_pkg::ST_TX) begin
               state_r <= spdts_pkg::ST_WAIT;
            end else if (!last_ack_r) begin
               state_r <= spdts_pkg::ST_WAIT;
            end else if (state_r == spdts_pkg::ST_SEL) begin
               // Acked protection reads carry no data; released line reads ones
               state_r <= rnw_r ? spdts_pkg::ST_WAIT : spdts_pkg::ST_RX;
               idx_r <= 2'h0;
            end else if (idx_r != `SPDTS_IDX_MAX) begin
               idx_r <= idx_r + 2'h1;
            end
         end else if (state_r == spdts_pkg::ST_TX) begin
            shift_r <= {shift_r[6:0], 1'b1};
            sda_oe_n <= shift_r[6];
         end
      end
   end

   // Memory section: address counter, page, write and standby control
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         page_select <= `SPDTS_PAGE_RST;
         mem_addr <= 8'h00;
         mem_wr_data <= 8'h00;
         mem_wr_stb <= 1'b0;
         mem_rd_stb <= 1'b0;
         mem_nv_write_start <= 1'b0;
         mem_standby <= 1'b1;
         wr_pend_r <= 1'b0;
      end else begin
         mem_wr_stb <= 1'b0;
         mem_rd_stb <= 1'b0;
         mem_nv_write_start <= 1'b0;
         mem_standby <= !((state_r == spdts_pkg::ST_RX || state_r == spdts_pkg::ST_TX
                          || tx_load) && tgt_r == spdts_pkg::TGT_MEM);
         if (start_det) begin
            wr_pend_r <= 1'b0;
         end else if (stop_det) begin
            wr_pend_r <= 1'b0;
            mem_nv_write_start <= wr_pend_r && stop_after_ack
                                  && tgt_r == spdts_pkg::TGT_MEM;
         end else if (byte_in && state_r == spdts_pkg::ST_SEL && ack_nxt
                      && tgt_nxt == spdts_pkg::TGT_PROT) begin
            if (pcmd_nxt == spdts_pkg::PC_PAGE0) begin
               page_select <= 1'b0;
            end else if (pcmd_nxt == spdts_pkg::PC_PAGE1) begin
               page_select <= 1'b1;
            end
         end else if (byte_in && state_r == spdts_pkg::ST_RX && tgt_r == spdts_pkg::TGT_MEM) begin
            if (idx_r == 2'h0) begin
               mem_addr <= shift_r;
            end else if (!blk_locked) begin
               // Increment wraps inside the write line; overflow is the master's fault
               mem_wr_data <= shift_r;
               mem_wr_stb <= 1'b1;
               wr_pend_r <= 1'b1;
               mem_addr[LINE_W-1:0] <= mem_addr[LINE_W-1:0] + 1'b1;
            end
         end else if (tx_load && tgt_r == spdts_pkg::TGT_MEM) begin
            mem_rd_stb <= 1'b1;
            mem_addr <= mem_addr + 8'h01;
         end
      end
   end

   // Protection commands act on the stop that follows an acked byte
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         prot_pend_r <= 1'b0;
         prot_clr_pend_r <= 1'b0;
         prot_blk_r <= 2'h0;
         block_protect_set <= 1'b0;
         block_protect_mask <= 4'h0;
         protect_clear_all <= 1'b0;
      end else begin
         block_protect_set <= 1'b0;
         protect_clear_all <= 1'b0;
         if (byte_in && state_r == spdts_pkg::ST_SEL) begin
            prot_pend_r <= ack_nxt && tgt_nxt == spdts_pkg::TGT_PROT
                           && pcmd_nxt == spdts_pkg::PC_SET;
            prot_clr_pend_r <= ack_nxt && tgt_nxt == spdts_pkg::TGT_PROT
                               && pcmd_nxt == spdts_pkg::PC_CLEAR;
            prot_blk_r <= blk_nxt;
         end else if (stop_det || start_det) begin
            prot_pend_r <= 1'b0;
            prot_clr_pend_r <= 1'b0;
            if (stop_after_ack && tgt_r == spdts_pkg::TGT_PROT) begin
               block_protect_set <= prot_pend_r;
               block_protect_mask <= 4'h1 << prot_blk_r;
               protect_clear_all <= prot_clr_pend_r;
            end
         end
      end
   end

   // Sensor section keeps its own pointer, untouched by memory traffic
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         ts_pointer <= 8'h00;
         ts_hi_r <= 8'h00;
         ts_wr_data <= 16'h0000;
         ts_wr_stb <= 1'b0;
      end else begin
         ts_wr_stb <= 1'b0;
         if (byte_in && state_r == spdts_pkg::ST_RX && tgt_r == spdts_pkg::TGT_TS) begin
            if (idx_r == 2'h0) begin
               ts_pointer <= shift_r;
            end else if (idx_r == 2'h1) begin
               ts_hi_r <= shift_r;
            end else if (idx_r == `SPDTS_TS_BYTES) begin
               ts_wr_data <= {ts_hi_r, shift_r};
               ts_wr_stb <= 1'b1;
            end
         end
      end
   end

endmodule

// ### include/spdts_cfg.svh
`ifndef SPDTS_CFG_SVH
`define SPDTS_CFG_SVH

// Device type codes, upper nibble of the select byte
`define SPDTS_TYPE_MEM 4'h_a
`define SPDTS_TYPE_PROT 4'h_6
`define SPDTS_TYPE_TS 4'h_3

// Protection-type encodings of {b3,b2,b1,direction}
`define SPDTS_PC_SET0 4'b0010
`define SPDTS_PC_SET1 4'b1000
`define SPDTS_PC_SET2 4'b1010
`define SPDTS_PC_SET3 4'b0000
`define SPDTS_PC_CLEAR 4'b0110
`define SPDTS_PC_QRY0 4'b0011
`define SPDTS_PC_QRY1 4'b1001
`define SPDTS_PC_QRY2 4'b1011
`define SPDTS_PC_QRY3 4'b0001
`define SPDTS_PC_PAGE0 4'b1100
`define SPDTS_PC_PAGE1 4'b1110
`define SPDTS_PC_PQRY 4'b1101

// Byte framing
`define SPDTS_ACK_SLOT 4'h_8
`define SPDTS_NEXT_SLOT 4'h_9
`define SPDTS_STOP_SLOT 4'h_1
`define SPDTS_TS_BYTES 2'h_2
`define SPDTS_IDX_MAX 2'h_3
`define SPDTS_LINE_W 4
`define SPDTS_IDLE_BYTE 8'h_ff
`define SPDTS_PAGE_RST 1'b0

`endif

// ### include/spdts_pkg.sv
package spdts_pkg;

   // Gray code along idle -> select -> receive -> transmit -> wait
   typedef enum logic [2:0] {
      ST_IDLE = 3'b000,
      ST_SEL = 3'b001,
      ST_RX = 3'b011,
      ST_TX = 3'b010,
      ST_WAIT = 3'b110
   } spdts_state_e;

   typedef enum logic [1:0] {
      TGT_NONE = 2'h0,
      TGT_MEM = 2'h1,
      TGT_PROT = 2'h2,
      TGT_TS = 2'h3
   } spdts_tgt_e;

   typedef enum logic [2:0] {
      PC_NONE = 3'h0,
      PC_SET = 3'h1,
      PC_CLEAR = 3'h2,
      PC_PAGE0 = 3'h3,
      PC_PAGE1 = 3'h4,
      PC_QUERY = 3'h5,
      PC_PQUERY = 3'h6
   } spdts_pcmd_e;

endpackage

// ### tb/spdts_i2c_front_monitor.sv
`timescale 1ns/1ps
module spdts_i2c_front_monitor #(
   parameter int LINE_W = 4
) (
   input wire logic clk,
   input wire logic nrst,
   input wire logic scl_in,
   input wire logic sda_in,
   input wire logic sda_out,
   input wire logic sda_oe_n,
   input wire logic high_voltage_level,
   input wire logic [3:0] prot_state,
   input wire logic page_select,
   input wire logic [7:0] mem_addr,
   input wire logic mem_wr_stb,
   input wire logic mem_rd_stb,
   input wire logic mem_nv_write_start,
   input wire logic mem_standby,
   input wire logic block_protect_set,
   input wire logic [3:0] block_protect_mask,
   input wire logic protect_clear_all
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!nrst);
   a_sda_low_only: assert property (sda_out == 1'b0)
      else $error("sda_out driven high");
   a_oe_fall_low: assert property ($fell(sda_oe_n) |-> !scl_in)
      else $error("data pulled while clock high");
   a_oe_hold_high: assert property (scl_in && $past(scl_in) |-> $stable(sda_oe_n))
      else $error("data changed while clock high");
   a_prot_no_write: assert property (
      mem_wr_stb |-> !prot_state[{page_select, mem_addr[7]}])
      else $error("write into protected block");
   a_set_onehot_hv: assert property (
      block_protect_set |-> $onehot(block_protect_mask) && high_voltage_level)
      else $error("bad protect set");
   a_clear_needs_hv: assert property (protect_clear_all |-> high_voltage_level)
      else $error("clear without high voltage");
   a_set_at_stop: assert property (block_protect_set |-> scl_in && sda_in)
      else $error("protect set outside stop");
   a_nv_at_stop: assert property (mem_nv_write_start |-> scl_in && sda_in && !mem_wr_stb)
      else $error("write cycle outside stop");
   a_page_after_rst: assert property ($past(nrst) == 1'b0 |-> !page_select)
      else $error("page not zero after reset");
   a_rd_active: assert property (mem_rd_stb |-> !mem_standby && !scl_in)
      else $error("read strobe in standby");
endmodule
bind spdts_i2c_front spdts_i2c_front_monitor #(.LINE_W(LINE_W)) i_spdts_i2c_front_monitor (.clk,
   .nrst, .scl_in, .sda_in, .sda_out, .sda_oe_n, .high_voltage_level, .prot_state,
   .page_select, .mem_addr, .mem_wr_stb, .mem_rd_stb, .mem_nv_write_start, .mem_standby,
   .block_protect_set, .block_protect_mask, .protect_clear_all);

// ### tb/spdts_i2c_master.sv
`timescale 1ns/1ps
module spdts_i2c_master (
   input wire logic clk,
   input wire logic sda,
   output logic scl,
   output logic sda_oe_n
);
   initial begin
      scl = 1'b1;
      sda_oe_n = 1'b1;
   end
   task automatic tick(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   task automatic start_cond();
      sda_oe_n = 1'b1;
      scl = 1'b0;
      tick(3);
      scl = 1'b1;
      tick(4);
      sda_oe_n = 1'b0;
      tick(4);
      scl = 1'b0;
      tick(1);
   endtask
   task automatic stop_cond();
      sda_oe_n = 1'b0;
      tick(3);
      scl = 1'b1;
      tick(4);
      sda_oe_n = 1'b1;
      tick(4);
   endtask
   // Clock falls one tick before data moves, so no false start or stop
   task automatic put_bit(input logic b);
      sda_oe_n = b;
      tick(3);
      scl = 1'b1;
      tick(4);
      scl = 1'b0;
      tick(1);
   endtask
   task automatic get_bit(output logic b);
      sda_oe_n = 1'b1;
      tick(3);
      scl = 1'b1;
      tick(2);
      b = sda;
      tick(2);
      scl = 1'b0;
      tick(1);
   endtask
   task automatic write_byte(input logic [7:0] d, output logic ack);
      logic b;
      for (int i = 7; i >= 0; i--) put_bit(d[i]);
      get_bit(b);
      ack = !b;
   endtask
   task automatic read_byte(input logic ack, output logic [7:0] d);
      for (int i = 7; i >= 0; i--) get_bit(d[i]);
      put_bit(!ack);
   endtask
endmodule

// ### tb/spdts_i2c_front_tb_top.sv
`timescale 1ns/1ps
`include "spdts_cfg.svh"
`define CHK(n, e, g) begin n_tests++; if ((g) !== (e)) begin num_errors++; \
   $display("unexpected %s exp %h got %h", n, e, g); end end
module spdts_i2c_front_tb_top;
   logic clk = 1'b0;
   logic nrst = 1'b0;
   logic hv = 1'b0;
   logic busy = 1'b0;
   logic [2:0] logical_select_address = 3'b101;
   logic [3:0] prot = 4'h_0;
   int num_errors = 0;
   int n_tests = 0;
   int n_wr = 0, n_nv = 0, n_set = 0, n_clr = 0, n_ts = 0;
   logic [7:0] wr_d;
   logic [3:0] set_m;
   wire scl, m_oe_n, sda_out, sda_oe_n, page_select, mem_wr_stb, mem_rd_stb;
   wire mem_nv_write_start, mem_standby, block_protect_set, protect_clear_all, ts_wr_stb;
   wire [7:0] mem_addr, mem_wr_data, ts_pointer;
   wire [3:0] block_protect_mask;
   wire [15:0] ts_wr_data;
   wire sda = m_oe_n & (sda_oe_n | sda_out);
   wire [7:0] mem_rd_data = mem_addr ^ (page_select ? 8'h_a5 : 8'h_3c);
   wire [15:0] ts_rd_data = {ts_pointer, ~ts_pointer};
   always #4 clk = ~clk;
   spdts_i2c_master i_spdts_i2c_master (.clk, .sda, .scl, .sda_oe_n(m_oe_n));
   spdts_i2c_front #(.LINE_W(4)) i_spdts_i2c_front (.clk, .nrst, .scl_in(scl), .sda_in(sda),
      .sda_out, .sda_oe_n, .first_address_pin(logical_select_address[0]), .second_address_pin(logical_select_address[1]),
      .third_address_pin(logical_select_address[2]), .high_voltage_level(hv), .mem_write_busy(busy),
      .mem_rd_data, .prot_state(prot), .ts_rd_data, .page_select, .mem_addr, .mem_wr_data,
      .mem_wr_stb, .mem_rd_stb, .mem_nv_write_start, .mem_standby, .block_protect_set,
      .block_protect_mask, .protect_clear_all, .ts_pointer, .ts_wr_data, .ts_wr_stb);
   always @(posedge clk) begin
      if (mem_wr_stb) begin
         n_wr++;
         wr_d <= mem_wr_data;
      end
      if (mem_nv_write_start) n_nv++;
      if (block_protect_set) begin
         n_set++;
         set_m <= block_protect_mask;
      end
      if (protect_clear_all) n_clr++;
      if (ts_wr_stb) n_ts++;
   end
   task automatic st(); i_spdts_i2c_master.start_cond(); endtask
   task automatic sp(); i_spdts_i2c_master.stop_cond(); endtask
   task automatic wb(input logic [7:0] d, input logic ea);
      logic a;
      i_spdts_i2c_master.write_byte(d, a);
      `CHK("ack", ea, a)
   endtask
   task automatic rb(input logic ma, input logic [7:0] ed);
      logic [7:0] d;
      i_spdts_i2c_master.read_byte(ma, d);
      `CHK("read byte", ed, d)
   endtask
   task automatic t_mem_write();
      int w0 = n_wr;
      int v0 = n_nv;
      st();
      wb(8'h_aa, 1'b1);
      wb(8'h_10, 1'b1);
      wb(8'h_5a, 1'b1);
      wb(8'h_c3, 1'b1);
      `CHK("wr count", 2, n_wr - w0)
      `CHK("wr data", 8'h_c3, wr_d)
      `CHK("wr addr", 8'h_12, mem_addr)
      sp();
      `CHK("nv start", 1, n_nv - v0)
   endtask
   task automatic t_mem_read(input logic [7:0] a, input logic [7:0] k);
      st();
      wb(8'h_aa, 1'b1);
      wb(a, 1'b1);
      st();
      wb(8'h_ab, 1'b1);
      rb(1'b1, a ^ k);
      rb(1'b0, (a + 8'h_01) ^ k);
      sp();
      `CHK("standby", 1'b1, mem_standby)
   endtask
   task automatic t_mismatch();
      st();
      wb(8'h_a8, 1'b0);
      wb(8'h_aa, 1'b0);
      sp();
      st();
      wb(8'h_38, 1'b0);
      sp();
   endtask
   task automatic t_sensor();
      int t0 = n_ts;
      busy = 1'b1;
      st();
      wb(8'h_aa, 1'b0);
      sp();
      st();
      wb(8'h_3a, 1'b1);
      wb(8'h_05, 1'b1);
      wb(8'h_12, 1'b1);
      wb(8'h_34, 1'b1);
      wb(8'h_56, 1'b0);
      sp();
      `CHK("ts pointer", 8'h_05, ts_pointer)
      `CHK("ts data", 16'h_1234, ts_wr_data)
      `CHK("ts strobe", 1, n_ts - t0)
      st();
      wb(8'h_3b, 1'b1);
      rb(1'b1, 8'h_05);
      rb(1'b0, 8'h_fa);
      sp();
      busy = 1'b0;
   endtask
   task automatic t_protect();
      logic [3:0] sc [4] = '{`SPDTS_PC_SET0, `SPDTS_PC_SET1, `SPDTS_PC_SET2, `SPDTS_PC_SET3};
      logic [3:0] qc [4] = '{`SPDTS_PC_QRY0, `SPDTS_PC_QRY1, `SPDTS_PC_QRY2, `SPDTS_PC_QRY3};
      int c0 = n_clr;
      // Pins 010 instead of 101 show the commands answer at a second device address
      logical_select_address = 3'b010;
      hv = 1'b1;
      for (int n = 0; n < 4; n++) begin
         st();
         wb({4'h_6, sc[n]}, 1'b1);
         sp();
         `CHK("protect mask", 4'h_1 << n, set_m)
      end
      `CHK("set count", 4, n_set)
      st();
      wb({4'h_6, `SPDTS_PC_CLEAR}, 1'b1);
      sp();
      hv = 1'b0;
      st();
      wb({4'h_6, `SPDTS_PC_CLEAR}, 1'b0);
      sp();
      `CHK("clear count", 1, n_clr - c0)
      foreach (qc[n]) begin
         prot = 4'h_5;
         st();
         wb({4'h_6, qc[n]}, !prot[n]);
         sp();
      end
      st();
      wb(8'h_64, 1'b0);
      sp();
      st();
      wb(8'h_67, 1'b0);
      sp();
      `CHK("set count", 4, n_set)
      logical_select_address = 3'b101;
      st();
      wb(8'h_aa, 1'b1);
      wb(8'h_10, 1'b1);
      wb(8'h_99, 1'b0);
      sp();
      `CHK("wr addr", 8'h_10, mem_addr)
      prot = 4'h_0;
   endtask
   task automatic t_page();
      st();
      wb({4'h_6, `SPDTS_PC_PAGE1}, 1'b1);
      sp();
      `CHK("page", 1'b1, page_select)
      st();
      wb({4'h_6, `SPDTS_PC_PQRY}, 1'b0);
      sp();
      t_mem_read(8'h_30, 8'h_a5);
      st();
      wb({4'h_6, `SPDTS_PC_PAGE0}, 1'b1);
      sp();
      `CHK("page", 1'b0, page_select)
      st();
      wb({4'h_6, `SPDTS_PC_PAGE1}, 1'b1);
      sp();
      nrst = 1'b0;
      i_spdts_i2c_master.tick(4);
      nrst = 1'b1;
      i_spdts_i2c_master.tick(2);
      `CHK("page", 1'b0, page_select)
      st();
      wb({4'h_6, `SPDTS_PC_PQRY}, 1'b1);
      sp();
   endtask
   task automatic complete_run();
      $display("checks %0d mismatches %0d", n_tests, num_errors);
      if (num_errors == 0 && n_tests > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask
   initial begin
      i_spdts_i2c_master.tick(4);
      nrst = 1'b1;
      i_spdts_i2c_master.tick(2);
      t_mem_write();
      t_mem_read(8'h_20, 8'h_3c);
      t_mismatch();
      t_sensor();
      t_protect();
      t_page();
      complete_run();
   end
   initial begin
      repeat (60000) @(posedge clk);
      num_errors++;
      complete_run();
   end
endmodule
